// ### tb_top.sv
// Bench for the frame builder: programs it over AHB-Lite, decodes frames.
// Assumes the client model and the constants header.
`timescale 1ns/1ps
`include "tsfb_defines.svh"
module tb_top;
  // Bus and reset drive.
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  // Design and model outputs.
  logic hreadyout;
  logic hresp;
  logic line_o;
  logic line_oe;
  logic frame_clk_o;
  logic [31:0] hrdata;
  logic [233:0] frame;
  logic [31:0] fcnt;
  logic [11:0] period;
  logic [7:0] cerr;
  logic [21:0] ts_seen;
  // Counters and scratch.
  int error_cnt = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic [21:0] ts;
  logic [7:0] dev_tab [5] = '{8'h00, 8'h29, 8'h42, 8'h6b, 8'he0};

  // 25 MHz core clock.
  always #20 core_clk = ~core_clk;

  tsfb_frame_builder u_tsfb_frame_builder (.core_clk(core_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .line_o(line_o), .line_oe(line_oe), .frame_clk_o(frame_clk_o));

  tsfb_client_model u_tsfb_client_model (.core_clk(core_clk), .rst_n(rst_n),
    .line_o(line_o), .frame_clk_o(frame_clk_o), .frame_r(frame), .cnt_r(fcnt),
    .period_r(period), .err_r(cerr), .ts_r(ts_seen));

  // Compares one value and counts it.
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Prints counts and verdict, then ends the run.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Waits for hready high at a rising edge, under a bound.
  task automatic wait_hready;
    int n;
    n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 100)
      begin
        error_cnt++;
        stop_test();
      end
      @(posedge core_clk);
    end
  endtask : wait_hready

  // One single word transfer; read data taken at the data phase edge.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_hready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~{24'h0, a};
    hwdata <= d;
    wait_hready();
    rd = hrdata;
    hwdata <= ~d;
  endtask : ahb

  // Reads a register and compares it.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // Waits until the model has decoded one more frame.
  task automatic wait_frame;
    int n;
    logic [31:0] f0;
    n = 0;
    f0 = fcnt;
    while (fcnt === f0)
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 6000)
      begin
        error_cnt++;
        stop_test();
      end
    end
  endtask : wait_frame

  // Serial check word over the payload bits, first bit first.
  function automatic logic [15:0] crc_calc(input logic [149:0] p);
    logic [15:0] c;
    logic fb;
    c = `TSFB_CRC_INIT;
    for (int i = 149; i >= 0; i--)
    begin
      fb = c[15] ^ p[i];
      c = {c[14:0], 1'b0};
      if (fb)
        c = c ^ `TSFB_CRC_POLY;
    end
    return c;
  endfunction : crc_calc

  // Whole expected frame; flag bit 7 goes out as zero.
  function automatic logic [233:0] exp_frame(input logic [7:0] dv, input logic [7:0] sf,
    input logic [21:0] t, input logic [23:0] ca);
    logic [149:0] p;
    p = {dv, sf & 8'h7f, t, 10'h0ff, ca, 10'h2a5, {68{1'b1}}};
    return {`TSFB_PREAMBLE, p, crc_calc(p)};
  endfunction : exp_frame

  // Main sequence.
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdchk(`TSFB_OFF_DEVTYPE, 32'h0);
    rdchk(`TSFB_OFF_SFLAGS, 32'h1);
    rdchk(`TSFB_OFF_ROUTE, 32'h0ff);
    ahb(1'b1, 8'h40, 32'h1234);
    rdchk(8'h40, 32'h0);
    check(line_oe, 1'b0);
    check(hresp, 1'b0);
    check(hreadyout, 1'b1);
    $display("test reset done");
    ahb(1'b1, `TSFB_OFF_CADV, 32'h123456);
    ahb(1'b1, `TSFB_OFF_ROUTE, 32'h2a5);
    ahb(1'b1, `TSFB_OFF_TSUP, 32'h3abcde);
    ahb(1'b1, `TSFB_OFF_TOD, 32'h5c);
    rdchk(`TSFB_OFF_TOD, 32'h15c);
    ahb(1'b1, `TSFB_OFF_CTRL, 32'h1);
    wait_frame();
    check(frame, exp_frame(8'h00, 8'h01, 22'h3abcde, 24'h123456));
    check(cerr, 8'h00);
    wait_frame();
    check(frame, exp_frame(8'h00, 8'h01, 22'h3abcdf, 24'h123456));
    check(period, 12'd2500);
    check(ts_seen, 22'h3abcdf);
    ahb(1'b0, `TSFB_OFF_FSTAT, 32'h0);
    check(rd & 32'h30000, 32'h10000);
    $display("test first frames done");
    for (int i = 0; i < 7; i++)
    begin
      ts = 22'h1000 * i + 22'h3;
      ahb(1'b1, `TSFB_OFF_DEVTYPE, {24'h0, dev_tab[i % 5]});
      ahb(1'b1, `TSFB_OFF_SFLAGS, 32'h80 | (32'h1 << i));
      ahb(1'b1, `TSFB_OFF_TSUP, {10'h0, ts});
      ahb(1'b1, `TSFB_OFF_CADV, 32'h10000 * i + 32'h80);
      wait_frame();
      wait_frame();
      check(frame,
        exp_frame(dev_tab[i % 5], 8'h80 | (8'h1 << i), ts, 24'h10000 * i + 24'h80));
    end
    $display("test field codes done");
    ahb(1'b1, `TSFB_OFF_CTRL, 32'h0);
    repeat (3) @(posedge core_clk);
    check(line_oe, 1'b0);
    check(frame_clk_o, 1'b0);
    $display("test disable done");
    stop_test();
  end
endmodule : tb_top

// ### tsfb_client_model.sv
// Client model: decodes the coded link back into frame bits.
// Assumes line and frame clock are sampled on the core clock.
`timescale 1ns/1ps
module tsfb_client_model
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Link from the server.
  input wire logic line_o,
  input wire logic frame_clk_o,
  // Decoded results for the bench.
  output logic [233:0] frame_r,
  output logic [31:0] cnt_r,
  output logic [11:0] period_r,
  output logic [7:0] err_r,
  output logic [21:0] ts_r
);
  // Frame clock delay, cycle in frame, stored half-bits.
  logic fck_r;
  logic [11:0] cyc_r;
  logic [467:0] half_r;
  // Decoded bits and count of bad pairs.
  logic [233:0] bits;
  logic [7:0] bad;

  // Each bit is its first half; the second half must be its inverse.
  always_comb
  begin
    bad = 8'h00;
    for (int i = 0; i < 234; i++)
    begin
      bits[233 - i] = half_r[467 - 2 * i];
      if (half_r[466 - 2 * i] === half_r[467 - 2 * i])
        bad = bad + 8'h01;
    end
  end

  // Counts cycles from the frame clock rise and samples each half-bit.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      fck_r <= 1'b0;
      cyc_r <= 12'hfff;
      half_r <= '0;
      frame_r <= '0;
      cnt_r <= 32'h0;
      period_r <= 12'h000;
      err_r <= 8'h00;
      ts_r <= 22'h0;
    end
    else
    begin
      fck_r <= frame_clk_o;
      if (frame_clk_o && !fck_r)
      begin
        cyc_r <= 12'h001;
        period_r <= cyc_r;
        half_r[467] <= line_o;
      end
      else if (cyc_r != 12'hfff)
        cyc_r <= cyc_r + 12'h001;
      if (cyc_r != 0 && cyc_r < 2500 && (468 * cyc_r) / 2500 != (468 * (cyc_r - 1)) / 2500)
        half_r[467 - (468 * cyc_r) / 2500] <= line_o;
      if (cyc_r == 12'd2499)
      begin
        frame_r <= bits;
        err_r <= bad;
        cnt_r <= cnt_r + 32'h1;
        if (bad == 8'h00 && bits[169:166] == 4'b1001)
          ts_r <= bits[149:128];
      end
    end
  end
endmodule : tsfb_client_model

// ### tsfb_defines.svh
// Constants of the timing server frame builder: offsets, field positions,
// reset values and timing counts. Included by the package and the design.
`ifndef TSFB_DEFINES_SVH
`define TSFB_DEFINES_SVH

// Core clock rate and frame rate in hertz.
`define TSFB_CLK_HZ 25000000
`define TSFB_FRAME_HZ 10000
// Cycles in one frame period and the Manchester half-bits that fill it.
`define TSFB_FRAME_CYC (`TSFB_CLK_HZ / `TSFB_FRAME_HZ)
`define TSFB_FRAME_BITS 234
`define TSFB_HALF_BITS (2 * `TSFB_FRAME_BITS)
// Frames per second and the time-of-day delivery window.
`define TSFB_FRAMES_PER_SEC 10000
`define TSFB_TOD_WIN_MS 100
`define TSFB_TOD_WIN_FRAMES (`TSFB_TOD_WIN_MS * `TSFB_FRAME_HZ / 1000)

// Preamble before coding, frame check polynomial and seed.
`define TSFB_PREAMBLE 68'haaaaaaaaaaaaaaaa9
`define TSFB_CRC_POLY 16'h1021
`define TSFB_CRC_INIT 16'hffff

// Bit indices within a frame: payload start, check word start.
`define TSFB_PAY_FIRST 68
`define TSFB_CRC_FIRST 218
`define TSFB_RSV_FIRST 150
`define TSFB_SR_W 218

// Register byte offsets on the bus.
`define TSFB_OFF_CTRL 8'h00
`define TSFB_OFF_DEVTYPE 8'h04
`define TSFB_OFF_SFLAGS 8'h08
`define TSFB_OFF_TSUP 8'h0c
`define TSFB_OFF_CADV 8'h10
`define TSFB_OFF_ROUTE 8'h14
`define TSFB_OFF_TOD 8'h18
`define TSFB_OFF_FSTAT 8'h1c

// Reset values of the software registers.
`define TSFB_RST_DEVTYPE 8'h00
`define TSFB_RST_SFLAGS 8'h01

`endif

// ### tsfb_frame_builder.sv
// Timing server frame builder: composes, Manchester-codes and sends one
// 234-bit frame every 100 us, with an AHB-Lite register slave.
// Assumes a single 25 MHz core clock and a zero-wait AHB-Lite master.
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tsfb_defines.svh"

module tsfb_frame_builder
  import tsfb_pkg::*;
(
  // Clock and synchronous reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Coded link and frame clock.
  output logic line_o,
  output logic line_oe,
  output logic frame_clk_o
);

  // Cycle and bit counts derived from the rates.
  localparam logic [11:0] FRAME_LAST = 12'(`TSFB_FRAME_CYC - 1);
  localparam logic [11:0] FRAME_CYC = 12'(`TSFB_FRAME_CYC);
  localparam logic [11:0] HALF_STEP = 12'(`TSFB_HALF_BITS);
  localparam logic [11:0] FCLK_HIGH = 12'(`TSFB_FRAME_CYC / 2);
  localparam logic [13:0] IDX_LAST = 14'(`TSFB_FRAMES_PER_SEC - 1);
  localparam logic [13:0] TOD_WIN = 14'(`TSFB_TOD_WIN_FRAMES);
  localparam logic [7:0] PAY_FIRST = 8'(`TSFB_PAY_FIRST);
  localparam logic [7:0] CRC_FIRST = 8'(`TSFB_CRC_FIRST);
  localparam logic [7:0] RSV_FIRST = 8'(`TSFB_RSV_FIRST);
  localparam logic [7:0] PAY_LAST = 8'(`TSFB_CRC_FIRST - 1);

  // One serial step of the frame check word.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[15] ^ b;
    crc_step = {c[14:0], 1'b0} ^ (fb ? `TSFB_CRC_POLY : 16'h0000);
  endfunction : crc_step

  // Software registers.
  logic en_r;
  logic [7:0] devtype_r;
  logic [7:0] sflags_r;
  logic [21:0] ts_r;
  logic [23:0] cadv_r;
  tsfb_slice_t route_r;
  logic [7:0] tod_byte_r;
  logic tod_pend_r;
  // Framing state.
  tsfb_state_t st_r;
  logic [11:0] fcnt_r;
  logic [11:0] acc_r;
  logic [8:0] half_r;
  logic [`TSFB_SR_W-1:0] sr_r;
  logic [15:0] crc_r;
  logic [13:0] fidx_r;
  logic pps_seen_r;
  // Bus data-phase capture.
  logic wr_pend_r;
  logic [7:0] waddr_r;

  // Decoded strobes and frame composition terms.
  logic running;
  logic load;
  logic tick;
  logic adv;
  logic [12:0] acc_sum;
  logic [7:0] bit_idx;
  logic [13:0] next_idx;
  logic tod_send;
  tsfb_slice_t tod_word;
  logic [7:0] sflags_tx;
  logic [15:0] crc_nx;
  logic aph;

  assign running = (st_r == TSFB_RUN);
  assign bit_idx = half_r[8:1];
  assign acc_sum = {1'b0, acc_r} + {1'b0, HALF_STEP};
  // A half-bit boundary falls wherever the accumulator wraps.
  assign tick = running && (acc_sum >= {1'b0, FRAME_CYC});
  assign adv = tick && half_r[0] && (fcnt_r != FRAME_LAST);
  // A new frame is loaded at the start and on the last cycle of each period.
  assign load = (!running && en_r) || (running && en_r && fcnt_r == FRAME_LAST);
  assign crc_nx = crc_step(crc_r, sr_r[`TSFB_SR_W-1]);

  // Index of the frame about to go out.
  assign next_idx = (!running || fidx_r == IDX_LAST) ? 14'h0000 : fidx_r + 14'h0001;

  assign tod_send = tod_pend_r && pps_seen_r && (next_idx < TOD_WIN);

  // Time-of-day slice: pulse flag, valid flag, byte or filler.
  always_comb
  begin
    tod_word = 10'h0ff;
    tod_word[9] = (next_idx == IDX_LAST);
    tod_word[8] = tod_send;
    tod_word[7:0] = tod_send ? tod_byte_r : 8'hff;
  end

  // reserved flag cleared
  // The reserved flag is forced low whatever software wrote.
  assign sflags_tx = {1'b0, sflags_r[6:0]};

  // State: run only while enabled; a restart always begins a clean frame.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_r <= TSFB_OFF;
    else if (en_r)
      st_r <= TSFB_RUN;
    else
      st_r <= TSFB_OFF;
  end

  // Frame period counter, one period per 10 kHz frame.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !running || fcnt_r == FRAME_LAST)
      fcnt_r <= 12'h000;
    else
      fcnt_r <= fcnt_r + 12'h001;
  end

  // Fractional rate accumulator: 468 half-bits land in exactly 2500 cycles,
  // so the last wrap coincides with the frame boundary and nothing drifts.
  // fixed bit rate
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !running)
      acc_r <= 12'h000;
    else if (tick)
      acc_r <= 12'(acc_sum - {1'b0, FRAME_CYC});
    else
      acc_r <= acc_sum[11:0];
  end

  // Half-bit counter within the frame.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !running || fcnt_r == FRAME_LAST)
      half_r <= 9'h000;
    else if (tick)
      half_r <= half_r + 9'h001;
  end

  // Frame shift register: fields in order, most significant bit first.
  // field order
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sr_r <= '0;
    else if (load)
      sr_r <= {`TSFB_PREAMBLE, devtype_r, sflags_tx, ts_r, tod_word, cadv_r,
               route_r, {68{1'b1}}};
    else if (adv && bit_idx == PAY_LAST)
      sr_r <= {crc_nx, {(`TSFB_SR_W-16){1'b0}}};
    else if (adv)
      sr_r <= {sr_r[`TSFB_SR_W-2:0], 1'b0};
  end

  // Frame check word over the payload bits only.
  // payload check
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || load)
      crc_r <= `TSFB_CRC_INIT;
    else if (adv && bit_idx >= PAY_FIRST && bit_idx <= PAY_LAST)
      crc_r <= crc_nx;
  end

  // Frame index within the second, and whether a pulse frame has gone out.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      fidx_r <= 14'h0000;
      pps_seen_r <= 1'b0;
    end
    else if (!en_r)
    begin
      fidx_r <= 14'h0000;
      pps_seen_r <= 1'b0;
    end
    else if (load)
    begin
      fidx_r <= next_idx;
      if (running && fidx_r == IDX_LAST)
        pps_seen_r <= 1'b1;
    end
  end

  // Upper timestamp: latched into the frame, then stepped by one frame.
  // A software write wins over the step in the same cycle.
  // upper timestamp
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ts_r <= 22'h000000;
    else if (wr_pend_r && waddr_r == `TSFB_OFF_TSUP)
      ts_r <= hwdata[21:0];
    else if (load)
      ts_r <= ts_r + 22'h000001;
  end

  // One-byte message holding register; a new byte wins over consumption.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tod_byte_r <= 8'h00;
      tod_pend_r <= 1'b0;
    end
    else if (wr_pend_r && waddr_r == `TSFB_OFF_TOD)
    begin
      tod_byte_r <= hwdata[7:0];
      tod_pend_r <= 1'b1;
    end
    else if (load && tod_send)
      tod_pend_r <= 1'b0;
  end

  // Configuration registers written by software.
  // timing source
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      en_r <= 1'b0;
      devtype_r <= `TSFB_RST_DEVTYPE;
      sflags_r <= `TSFB_RST_SFLAGS;
      cadv_r <= 24'h000000;
      route_r <= 10'h0ff;
    end
    else if (wr_pend_r)
    begin
      // Unmapped offsets fall through and are ignored.
      case (waddr_r)
        `TSFB_OFF_CTRL: en_r <= hwdata[0];
        `TSFB_OFF_DEVTYPE: devtype_r <= hwdata[7:0];
        `TSFB_OFF_SFLAGS: sflags_r <= hwdata[7:0];
        `TSFB_OFF_CADV: cadv_r <= hwdata[23:0];
        `TSFB_OFF_ROUTE: route_r <= hwdata[9:0];
        default: ;
      endcase
    end
  end

  // Bus address phase accepted; the slave never stretches a transfer.
  assign aph = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address-phase capture for the write data phase that follows.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wr_pend_r <= 1'b0;
      waddr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= aph && hwrite;
      waddr_r <= haddr[7:0];
    end
  end

  // Read data is registered at the address phase so it stands in the data phase.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      hrdata <= 32'h00000000;
    else if (aph && !hwrite)
    begin
      case (haddr[7:0])
        `TSFB_OFF_CTRL: hrdata <= {31'h00000000, en_r};
        `TSFB_OFF_DEVTYPE: hrdata <= {24'h000000, devtype_r};
        `TSFB_OFF_SFLAGS: hrdata <= {24'h000000, sflags_r};
        `TSFB_OFF_TSUP: hrdata <= {10'h000, ts_r};
        `TSFB_OFF_CADV: hrdata <= {8'h00, cadv_r};
        `TSFB_OFF_ROUTE: hrdata <= {22'h000000, route_r};
        `TSFB_OFF_TOD: hrdata <= {23'h000000, tod_pend_r, tod_byte_r};
        `TSFB_OFF_FSTAT: hrdata <= {14'h0000, pps_seen_r, running, 2'h0, fidx_r};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // Line and frame clock come from flip-flops, so both lag the counters
  // by one cycle and stay aligned with each other.
  // frame clock edge
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      line_o <= 1'b0;
      line_oe <= 1'b0;
      frame_clk_o <= 1'b0;
    end
    else
    begin
      line_o <= running && (sr_r[`TSFB_SR_W-1] ^ half_r[0]);
      line_oe <= running;
      frame_clk_o <= running && (fcnt_r < FCLK_HIGH);
    end
  end

  // Mid-bit transition of the coded line.
  sequence s_mid_bit;
    tick && !half_r[0];
  endsequence

  // Last cycle of a frame period while still enabled.
  sequence s_frame_end;
    running && en_r && fcnt_r == FRAME_LAST;
  endsequence

  AST_HALF_FILL: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_frame_end |-> tick && half_r == 9'(`TSFB_HALF_BITS - 1))
    else $error("half-bit count does not fill the frame");

  AST_MID_TOGGLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_mid_bit ##1 running |=> line_o != $past(line_o))
    else $error("line missed a mid-bit transition");

  AST_PREAMBLE_ALT: assert property (@(posedge core_clk) disable iff (!rst_n)
    running && bit_idx < 8'd64 |-> sr_r[`TSFB_SR_W-1] == ~bit_idx[0])
    else $error("preamble bit not alternating");

  AST_PREAMBLE_TAIL: assert property (@(posedge core_clk) disable iff (!rst_n)
    running && bit_idx >= 8'd64 && bit_idx < PAY_FIRST |->
      sr_r[`TSFB_SR_W-1] == (bit_idx == 8'd64 || bit_idx == 8'd67))
    else $error("preamble tail is not 1001");

  AST_RSV_ONES: assert property (@(posedge core_clk) disable iff (!rst_n)
    running && bit_idx >= RSV_FIRST && bit_idx < CRC_FIRST |-> sr_r[`TSFB_SR_W-1])
    else $error("reserved bit sent as zero");

  AST_CRC_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
    adv && bit_idx == PAY_LAST |=> sr_r[`TSFB_SR_W-1 -: 16] == $past(crc_nx))
    else $error("check word not loaded after payload");

  AST_FLAG7_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    load |=> sr_r[141] == 1'b0)
    else $error("reserved status flag sent as one");

  AST_TS_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
    load && !wr_pend_r |=> ts_r == $past(ts_r) + 22'h000001 && sr_r[133:112] == $past(ts_r))
    else $error("upper timestamp not latched and stepped");

  AST_TOD_FILL: assert property (@(posedge core_clk) disable iff (!rst_n)
    load && !tod_send |=> sr_r[109:102] == 8'hff && !sr_r[110])
    else $error("idle message byte not all ones");

  AST_TOD_WINDOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    tod_send |-> pps_seen_r && next_idx < TOD_WIN && next_idx != IDX_LAST)
    else $error("message byte outside its window");

  AST_PPS_ONCE: assert property (@(posedge core_clk) disable iff (!rst_n)
    load |=> sr_r[111] == (fidx_r == IDX_LAST))
    else $error("pulse flag in wrong frame");

  AST_FCLK_RISE: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(frame_clk_o) |-> $past(fcnt_r) == 12'h000 && $past(half_r) == 9'h000)
    else $error("frame clock not aligned to first preamble bit");

endmodule : tsfb_frame_builder

// ### tsfb_pkg.sv
// Types shared by the timing server frame builder.
// Assumes the constants header is on the include path.
`include "tsfb_defines.svh"

package tsfb_pkg;

  // Transmitter state, one-hot.
  typedef enum logic [1:0]
  {
    TSFB_OFF = 2'b01,
    TSFB_RUN = 2'b10
  } tsfb_state_t;

  // A ten bit frame slice (time-of-day or route trace).
  typedef logic [9:0] tsfb_slice_t;

endpackage : tsfb_pkg
